//--- core/tsp_map.svh
// Offsets, field positions, reset values and timing counts of the single pulse timer
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH
`define TSP_ADDR_W        4
// Register offsets
`define TSP_OFF_CTRL      4'h0
`define TSP_OFF_CMPA      4'h1
`define TSP_OFF_CMPP      4'h2
`define TSP_OFF_COUNT     4'h3
`define TSP_OFF_STATUS    4'h4
`define TSP_OFF_MASK      4'h5
// Control field positions
`define TSP_CTRL_RUN      0
`define TSP_CTRL_PAUSE    1
`define TSP_CTRL_OCLV     2
`define TSP_CTRL_POL      3
`define TSP_CTRL_CCLR     4
`define TSP_CTRL_IO_LO    5
`define TSP_CTRL_IO_HI    6
`define TSP_CTRL_MD_LO    7
`define TSP_CTRL_MD_HI    8
`define TSP_CTRL_TRGEDGE  9
// Status field positions
`define TSP_ST_AF         0
`define TSP_ST_PF         1
// Mode codes
`define TSP_MODE_PULSE    2'h2
`define TSP_IO_PULSE      2'h3
// Reset values
`define TSP_CTRL_RST      10'h000
`define TSP_CMP_RST       10'h000
`define TSP_MASK_RST      2'h0
// Counting clock: one tick every TSP_TICK_DIV system clocks
`define TSP_TICK_DIV      4
`endif

//--- core/tsp_pkg.sv
// Types shared by the single pulse timer files
`default_nettype none
package tsp_pkg;
  // Register bus request
  typedef struct packed {
    logic [3:0]  addr;  // Word address
    logic [31:0] wdata; // Write data
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
  } tsp_req_t;
  // Pulse engine state
  typedef enum logic [0:0] {TSP_IDLE, TSP_ACTIVE} tsp_state_t;
endpackage : tsp_pkg
`default_nettype wire

//--- core/tsp_tick.sv
// Counting clock enable divider
`timescale 1ns/1ps
`default_nettype none
module tsp_tick #(
  parameter int DIV = 4
) (
  input  wire logic CLK,  // System clock
  input  wire logic NRST, // Asynchronous reset, active low
  output logic      TICK  // One-cycle enable pulse
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt_reg;  // Divider count
  logic [W-1:0] cnt_next; // Next divider count
  // Elaboration check: a divide by zero or less has no meaning
  if (DIV < 1) begin : g_bad_div
    $error("tsp_tick: DIV must be at least 1");
  end
  // ==========================================
  // Divider
  always_comb begin
    cnt_next = (cnt_reg == W'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) cnt_reg <= '0;
    else cnt_reg <= cnt_next;
  end
  assign TICK = (cnt_reg == W'(DIV - 1));
endmodule : tsp_tick
`default_nettype wire

//--- core/tsp_timer.sv
// Periodic timer in single pulse output mode with register port and interrupt
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_map.svh"
module tsp_timer #(
  parameter int CW  = 10,              // Counter width
  parameter int DIV = `TSP_TICK_DIV    // System clocks per count
) (
  input  wire logic        CLK,        // System clock
  input  wire logic        NRST,       // Asynchronous reset, active low
  input  wire logic [3:0]  ADDR,       // Register word address
  input  wire logic [31:0] WDATA,      // Write data
  input  wire logic        WR,         // Write strobe
  input  wire logic        RD,         // Read strobe
  output logic      [31:0] RDATA,      // Read data, cycle after RD
  input  wire logic        TRIG_IN,    // External trigger pin
  output logic             PULSE_OUT,  // Timer output pin
  output logic             IRQ         // Level interrupt
);
  // Elaboration check: read path and reset values are laid out for ten bits
  if (CW != 10) begin : g_bad_cw
    $error("tsp_timer: counter width must be 10");
  end
  // ==========================================
  // Declarations
  tsp_pkg::tsp_req_t   req;           // Bundled bus request
  tsp_pkg::tsp_state_t st_reg;        // Pulse state
  tsp_pkg::tsp_state_t st_next;       // Next pulse state
  logic [9:0]    ctrl_reg;            // Control bits
  logic [9:0]    ctrl_next;           // Next control bits
  logic [CW-1:0] cmpa_reg;            // Compare-A value
  logic [CW-1:0] cmpa_next;           // Next compare-A
  logic [CW-1:0] cmpp_reg;            // Period compare, unused here
  logic [CW-1:0] cmpp_next;           // Next period compare
  logic [CW-1:0] cnt_reg;             // Timer counter
  logic [CW-1:0] cnt_next;            // Next counter
  logic [1:0]    stat_reg;            // Sticky flags
  logic [1:0]    stat_next;           // Next flags
  logic [1:0]    mask_reg;            // Interrupt mask
  logic [1:0]    mask_next;           // Next mask
  logic          run_d_reg;           // Run bit one cycle ago
  logic          trig_d_reg;          // Trigger pin one cycle ago
  logic          out_reg;             // Raw output level
  logic          out_next;            // Next raw output
  logic [31:0]   rdata_reg;           // Read data register
  logic [31:0]   rdata_next;          // Next read data
  logic          tick;                // Counting clock enable
  logic          pulse_mode;          // Single pulse mode selected
  logic          run_rise;            // Run bit rising edge
  logic          trig_edge;           // Active trigger edge
  logic          match_a;             // Compare-A hit this tick
  logic          wr_ctrl;             // Control write
  logic [9:0]    ctrl_w;              // Control after write/trigger

  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Address decode used by the write paths; the read path decodes with a case
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction : hit

  tsp_tick #(.DIV(DIV)) u_tick (
    .CLK  (CLK),
    .NRST (NRST),
    .TICK (tick)
  );

  // ==========================================
  // Mode and events
  // Only mode 10 with action 11 runs the pulse engine; software sets it
  assign pulse_mode = (ctrl_reg[`TSP_CTRL_MD_HI:`TSP_CTRL_MD_LO] == `TSP_MODE_PULSE) &&
                      (ctrl_reg[`TSP_CTRL_IO_HI:`TSP_CTRL_IO_LO] == `TSP_IO_PULSE);
  // Edge polarity chosen by a control bit; pin is synchronous
  assign trig_edge = ctrl_reg[`TSP_CTRL_TRGEDGE] ? (trig_d_reg & ~TRIG_IN)
                                                 : (~trig_d_reg & TRIG_IN);
  assign run_rise  = ctrl_reg[`TSP_CTRL_RUN] & ~run_d_reg;
  // Full-width equality, only while the counter really advances
  // A cleared run bit stops matching at once, before the state has dropped,
  // so a software stop can never raise a stray compare-A flag
  assign match_a   = pulse_mode && st_reg == tsp_pkg::TSP_ACTIVE && tick &&
                     ctrl_reg[`TSP_CTRL_RUN] &&
                     !ctrl_reg[`TSP_CTRL_PAUSE] && !run_rise &&
                     (cnt_reg + 1'b1 == cmpa_reg);
  assign wr_ctrl   = req.wr && hit(req.addr, `TSP_OFF_CTRL);

  // ==========================================
  // Register file next values
  always_comb begin
    ctrl_w    = wr_ctrl ? req.wdata[9:0] : ctrl_reg;
    if (pulse_mode && trig_edge) begin
      ctrl_w[`TSP_CTRL_RUN] = 1'b1;
    end
    ctrl_next = ctrl_w;
    // Match clears run; the period compare and clear select play no part
    if (match_a) begin
      ctrl_next[`TSP_CTRL_RUN] = 1'b0;
    end
    cmpa_next = (req.wr && hit(req.addr, `TSP_OFF_CMPA)) ? req.wdata[CW-1:0] : cmpa_reg;
    cmpp_next = (req.wr && hit(req.addr, `TSP_OFF_CMPP)) ? req.wdata[CW-1:0] : cmpp_reg;
    mask_next = (req.wr && hit(req.addr, `TSP_OFF_MASK)) ? req.wdata[1:0] : mask_reg;
    // Write one clears; a new event in the same cycle wins
    stat_next = stat_reg;
    if (req.wr && hit(req.addr, `TSP_OFF_STATUS)) begin
      stat_next = stat_reg & ~req.wdata[1:0];
    end
    if (match_a) begin
      stat_next[`TSP_ST_AF] = 1'b1;
    end
  end

  // ==========================================
  // Counter and output engine
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (!pulse_mode) begin
      st_next  = tsp_pkg::TSP_IDLE;
      out_next = ctrl_reg[`TSP_CTRL_OCLV];
    end else if (run_rise) begin
      // Restart from zero, pulse leading edge at once
      st_next  = tsp_pkg::TSP_ACTIVE;
      cnt_next = '0;
      out_next = ~ctrl_reg[`TSP_CTRL_OCLV];
    end else if (!ctrl_reg[`TSP_CTRL_RUN]) begin
      // Trailing edge; count is held, not cleared
      st_next  = tsp_pkg::TSP_IDLE;
      out_next = ctrl_reg[`TSP_CTRL_OCLV];
    end else if (tick && !ctrl_reg[`TSP_CTRL_PAUSE]) begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // ==========================================
  // Read path: data stand one cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (req.rd) begin
      unique case (req.addr)
        `TSP_OFF_CTRL:   rdata_next = {22'h0, ctrl_reg};
        `TSP_OFF_CMPA:   rdata_next = {22'h0, cmpa_reg};
        `TSP_OFF_CMPP:   rdata_next = {22'h0, cmpp_reg};
        `TSP_OFF_COUNT:  rdata_next = {22'h0, cnt_reg};
        `TSP_OFF_STATUS: rdata_next = {30'h0, stat_reg};
        `TSP_OFF_MASK:   rdata_next = {30'h0, mask_reg};
        default:         rdata_next = '0;  // Unmapped reads zero
      endcase
    end
  end

  // ==========================================
  // State registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_reg   <= `TSP_CTRL_RST;
      cmpa_reg   <= `TSP_CMP_RST;
      cmpp_reg   <= `TSP_CMP_RST;
      cnt_reg    <= '0;
      stat_reg   <= 2'h0;
      mask_reg   <= `TSP_MASK_RST;
      st_reg     <= tsp_pkg::TSP_IDLE;
      run_d_reg  <= 1'b0;
      trig_d_reg <= 1'b0;
      out_reg    <= 1'b0;
      rdata_reg  <= 32'h0;
    end else begin
      ctrl_reg   <= ctrl_next;
      cmpa_reg   <= cmpa_next;
      cmpp_reg   <= cmpp_next;
      cnt_reg    <= cnt_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
      st_reg     <= st_next;
      run_d_reg  <= ctrl_reg[`TSP_CTRL_RUN];
      trig_d_reg <= TRIG_IN;
      out_reg    <= out_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Polarity invert sits after the engine so it never disturbs timing
  assign PULSE_OUT = out_reg ^ ctrl_reg[`TSP_CTRL_POL];
  assign RDATA     = rdata_reg;
  assign IRQ       = |(stat_reg & mask_reg);

  // ==========================================
  // Assertions
  a_match_stops_run: assert property (@(posedge CLK) disable iff (!NRST)
    match_a && !wr_ctrl |=> !ctrl_reg[`TSP_CTRL_RUN])
    else $error("run bit not cleared by compare-A match");
  a_match_sets_flag: assert property (@(posedge CLK) disable iff (!NRST)
    match_a |=> stat_reg[`TSP_ST_AF])
    else $error("compare-A flag not set");
  a_trig_sets_run: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && trig_edge && !match_a |=> ctrl_reg[`TSP_CTRL_RUN])
    else $error("trigger did not set run bit");
  a_rise_starts: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && run_rise |=> out_reg != ctrl_reg[`TSP_CTRL_OCLV] && cnt_reg == '0)
    else $error("pulse did not start on run rising edge");
  a_stop_ends: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && !ctrl_reg[`TSP_CTRL_RUN] && !wr_ctrl |=> out_reg == $past(ctrl_reg[`TSP_CTRL_OCLV]))
    else $error("output not idle after run cleared");
  a_count_held: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && !ctrl_reg[`TSP_CTRL_RUN] |=> $stable(cnt_reg))
    else $error("counter changed while stopped");
  a_pause_holds: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && ctrl_reg[`TSP_CTRL_PAUSE] && !run_rise |=> $stable(cnt_reg))
    else $error("counter moved while paused");
  a_match_equal: assert property (@(posedge CLK) disable iff (!NRST)
    match_a |=> cnt_reg == cmpa_reg)
    else $error("match without equal count");
  a_irq_level: assert property (@(posedge CLK) disable iff (!NRST)
    stat_reg[`TSP_ST_AF] && mask_reg[`TSP_ST_AF] |-> IRQ)
    else $error("interrupt not raised");
  // The flag may only come up through a real compare-A match
  a_flag_cause: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(stat_reg[`TSP_ST_AF]) |-> $past(match_a))
    else $error("compare-A flag set without a match");
  // Outside a run rising edge the count only holds or steps by one
  a_no_stray_clear: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && !run_rise |=> cnt_reg == $past(cnt_reg) || cnt_reg == $past(cnt_reg) + 10'h001)
    else $error("counter cleared outside a run rising edge");
  // A trigger edge on a stopped timer gives a run rising edge next cycle
  a_trig_start: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && trig_edge && !ctrl_reg[`TSP_CTRL_RUN] |=> run_rise)
    else $error("trigger edge did not start the pulse");
  // Pausing freezes the count but keeps the pulse active
  a_pause_active: assert property (@(posedge CLK) disable iff (!NRST)
    pulse_mode && ctrl_reg[`TSP_CTRL_PAUSE] && ctrl_reg[`TSP_CTRL_RUN] &&
    st_reg == tsp_pkg::TSP_ACTIVE |=> st_reg == tsp_pkg::TSP_ACTIVE)
    else $error("pulse ended while paused");
endmodule : tsp_timer
`default_nettype wire

//--- test/tsp_trig_model.sv
// Partner model: external trigger source on the trigger pin
`timescale 1ns/1ps
`default_nettype none
module tsp_trig_model (
  input  wire logic CLK,     // System clock
  input  wire logic FIRE,    // One-cycle request for an active edge
  input  wire logic FALL,    // Active edge is falling when high
  output logic      TRIG_IN  // Trigger pin
);
  int hold; // Cycles left at the active level
  initial begin
    TRIG_IN = 1'b0;
    hold    = 0;
  end
  // ==========================================
  // Edge maker: rest at the inactive level, leave it briefly on request
  always @(posedge CLK) begin
    if (FIRE) begin
      hold <= 3;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
    // Holding a few cycles keeps the edge clear of any sampling doubt
    TRIG_IN <= (FIRE || hold > 1) ? ~FALL : FALL;
  end
endmodule : tsp_trig_model
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the single pulse timer
`timescale 1ns/1ps
`default_nettype none
`include "tsp_map.svh"
module testbench;
  logic        CLK, NRST, WR, RD, PULSE_OUT, IRQ, TRIG_IN, fire, fall, act, cc;
  logic [3:0]  ADDR;                        // Bus address
  logic [31:0] WDATA, RDATA, d, d1, cw;     // Bus data and scratch
  logic [9:0]  cmpa;                        // Compare value under test
  int          miscompares, n_compared, seed, w, i;
  int          cycles = 0;                  // Watchdog count

  tsp_timer #(.DIV(1)) DUT (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TRIG_IN(TRIG_IN), .PULSE_OUT(PULSE_OUT), .IRQ(IRQ));
  tsp_trig_model PART (.CLK(CLK), .FIRE(fire), .FALL(fall), .TRIG_IN(TRIG_IN));

  // ==========================================
  // Helpers
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= v;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  // Control word with pulse mode 10 and output action 11 always set
  function automatic logic [31:0] ctl(input logic r, p, oc, pl, c, fe);
    return {22'h000000, fe, 2'h2, 2'h3, c, pl, oc, p, r};
  endfunction : ctl
  // Bounded wait for the pin to reach a level
  task automatic wait_pin(input logic lv);
    w = 0;
    #1;
    while (PULSE_OUT !== lv && w < 8) begin
      @(posedge CLK);
      #1 w++;
    end
  endtask : wait_pin

  // ==========================================
  // Clock and watchdog
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    seed = 228;
    NRST = 1'b0;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 4'h0;
    WDATA = 32'h0;
    fire = 1'b0;
    fall = 1'b0;
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    check("pin at reset", {31'h0, PULSE_OUT}, 32'h0);
    for (i = 0; i < 7; i++) begin
      rd((i == 6) ? 4'hf : i[3:0]); // Unmapped read returns zero
      check("reset value", d, 32'h0);
    end
    // Pulses: corner compare values first, then random ones
    for (i = 0; i < 6; i++) begin
      cmpa = (i == 0) ? 10'h001 : (i == 1) ? 10'h3ff : 10'(($random(seed) & 63) + 2);
      act  = ~(i[0] ^ i[1]);
      cc   = 1'($random(seed));
      wr(`TSP_OFF_MASK, {31'h0, i[0]});
      wr(`TSP_OFF_CMPA, {22'h0, cmpa});
      wr(`TSP_OFF_CMPP, {22'h0, cmpa >> 1}); // Period value must not cut the pulse
      cw = ctl(1'b0, 1'b0, i[0], i[1], cc, i[1]);
      if (i[0]) begin
        wr(`TSP_OFF_CTRL, cw);
        fall <= i[1];
        repeat (3) @(posedge CLK);
        fire <= 1'b1;
        @(posedge CLK);
        fire <= 1'b0;
      end else begin
        wr(`TSP_OFF_CTRL, cw | 32'h1);
      end
      wait_pin(act);
      check("pulse start", {31'h0, PULSE_OUT}, {31'h0, act});
      w = 0;
      while (PULSE_OUT === act && w < 1100) begin
        @(posedge CLK);
        #1 w++;
      end
      check("pulse width", {31'h0, (w >= cmpa && w <= cmpa + 2)}, 32'h1);
      rd(`TSP_OFF_COUNT);
      check("count at match", d, {22'h0, cmpa});
      rd(`TSP_OFF_CTRL);
      check("run cleared", d, cw);
      rd(`TSP_OFF_STATUS);
      check("match flag", d, 32'h1);
      check("irq masked", {31'h0, IRQ}, {31'h0, i[0]});
      wr(`TSP_OFF_STATUS, 32'h1);
      rd(`TSP_OFF_STATUS);
      check("flag cleared", {30'h0, d[0], IRQ}, 32'h0);
    end
    // Pause, early stop and restart
    wr(`TSP_OFF_CMPA, 32'h0c8);
    wr(`TSP_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (20) @(posedge CLK);
    wr(`TSP_OFF_CTRL, ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    rd(`TSP_OFF_COUNT);
    d1 = d;
    rd(`TSP_OFF_COUNT);
    check("paused count", d, d1);
    check("pulse while paused", {31'h0, PULSE_OUT}, 32'h1);
    wr(`TSP_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    rd(`TSP_OFF_COUNT);
    check("resumed", {31'h0, d > d1}, 32'h1);
    wr(`TSP_OFF_CTRL, ctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0));
    wait_pin(1'b0);
    check("early stop", {31'h0, PULSE_OUT}, 32'h0);
    rd(`TSP_OFF_COUNT);
    d1 = d;
    repeat (5) @(posedge CLK);
    rd(`TSP_OFF_COUNT);
    check("held count", d, d1);
    check("count kept", {31'h0, d > 32'h14}, 32'h1);
    wr(`TSP_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0));
    rd(`TSP_OFF_COUNT);
    check("restart from zero", {31'h0, d < 32'h8}, 32'h1);
    rd(`TSP_OFF_STATUS);
    check("no match flag", d, 32'h0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
